// ==== design/xcvr_reconfig_pkg.sv ====
// shared constants, types and carriers of the reconfiguration controller
package xcvr_reconfig_pkg;

	// ************************************************
	// widths
	// ************************************************
	localparam int IDX_W = 6;
	localparam int WORD_W = 16;
	localparam int MEM_DEPTH = 64;
	localparam int MODE_W = 3;
	typedef logic [IDX_W-1:0] idx_t;
	typedef logic [WORD_W-1:0] word_t;

	// ************************************************
	// register map
	// ************************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_IMG_ADDR = 8'h08;
	localparam logic [7:0] OFS_IMG_DATA = 8'h0c;
	localparam logic [3:0] SEL_NONE = 4'h0;
	localparam logic [3:0] SEL_CTRL = 4'h1;
	localparam logic [3:0] SEL_STATUS = 4'h2;
	localparam logic [3:0] SEL_IMG_ADDR = 4'h4;
	localparam logic [3:0] SEL_IMG_DATA = 4'h8;
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_LAST_LSB = 8;
	localparam int CTRL_START_BIT = 16;
	localparam int CTRL_CLEAR_BIT = 17;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_DONE_BIT = 1;
	localparam int ST_LOADING_BIT = 2;
	localparam int ST_MODE_ERR_BIT = 3;
	localparam int ST_OC_DONE_BIT = 4;
	localparam int ST_IDX_LSB = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ************************************************
	// modes, reset values, timing
	// ************************************************
	localparam logic [MODE_W-1:0] MODE_ANALOG = 3'h0;
	localparam logic [MODE_W-1:0] MODE_CHANNEL = 3'h1;
	localparam logic [MODE_W-1:0] RST_MODE = MODE_ANALOG;
	localparam idx_t RST_LAST = 6'h3f;
	localparam int OC_CYCLES = 16;
	localparam logic [3:0] OC_SETTLE_LAST = 4'(OC_CYCLES - 3);

	// ************************************************
	// states and carriers
	// ************************************************
	typedef enum logic [4:0] {
		OC_WAIT = 5'h01,
		OC_ISOLATE = 5'h02,
		OC_SETTLE = 5'h04,
		OC_BUFFER = 5'h08,
		OC_DONE = 5'h10
	} oc_state_t;
	typedef enum logic [2:0] {
		LD_IDLE = 3'h1,
		LD_FETCH = 3'h2,
		LD_WRITE = 3'h4
	} ld_state_t;
	typedef struct packed {
		logic rx_isolate;
		logic oc_settle;
		logic oc_buffer;
		logic wr_en;
		idx_t wr_addr;
		word_t wr_data;
	} to_xcvr_t;
	typedef struct packed {
		logic wr_ack;
	} from_xcvr_t;

endpackage : xcvr_reconfig_pkg

// ==== design/xcvr_reconfig_offset_cancel.sv ====
// channel image loader and power-up offset cancellation sequencer
//
// Contract
// R1: word index counts up, wraps to zero
// R2: index strobe after each full 16-bit word
// R3: one-cycle clear pulse zeroes word index
// R4: controller reset clears registers, aborts load
// R5: reset source synchronised to sys_clk outside
// R6: load complete raised after last word
// R7: load complete cleared when new load starts
// R8: offset cancellation runs after power-up
// R9: offset cancellation runs once per power-up
// R10: held reset at power-up delays start
// R11: reset mid-sequence restarts it afterwards
// R12: sequence first isolates receiver input pins
// R13: last step cancels receiver buffer offset
// R14: power-down kept low during sequence outside
// R15: busy low first cycle, high second
// R16: busy falls when cancellation completes
// R17: cancellation lasts sixteen clock cycles
// R18: outbound and inbound transceiver buses
// R19: no cancellation without a receiver
// R20: no pll reconfiguration function offered
// R21: mode 000 analog, 001 channel, others invalid; here a start in mode 000 also sets the mode error and loads nothing
// R22: all outputs registered on sys_clk
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps

module xcvr_reconfig_offset_cancel #(
	parameter bit HAS_RX = 1'b1
) (
	// clock and resets
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic por_n,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// transceiver buses
	output xcvr_reconfig_pkg::to_xcvr_t to_xcvr,
	input wire xcvr_reconfig_pkg::from_xcvr_t from_xcvr,
	// status
	output logic busy,
	output xcvr_reconfig_pkg::idx_t word_idx,
	output logic word_idx_strobe,
	output logic load_done
);
	import xcvr_reconfig_pkg::*;

	// ************************************************
	// declarations
	// ************************************************
	logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg, wdata_reg, rd_word;
	logic [7:0] awaddr_reg;
	logic [3:0] wstrb_reg, wsel, rsel;
	logic wr_fire, start_ok;
	logic [MODE_W-1:0] mode_reg;
	idx_t last_reg, img_addr_reg, word_idx_reg, wr_addr_reg;
	word_t wr_data_reg;
	word_t img_mem [MEM_DEPTH];
	logic start_req_reg, clr_req_reg, mode_err_reg;
	logic strobe_reg, load_done_reg, wr_en_reg;
	ld_state_t ld_state_reg;
	oc_state_t oc_state_reg;
	logic [3:0] oc_cnt_reg;
	logic busy_reg, oc_done_reg, isolate_reg, settle_reg, buffer_reg;

	function automatic logic [3:0] reg_hit(input logic [7:0] a);
		case (a)
			OFS_CTRL: reg_hit = SEL_CTRL;
			OFS_STATUS: reg_hit = SEL_STATUS;
			OFS_IMG_ADDR: reg_hit = SEL_IMG_ADDR;
			OFS_IMG_DATA: reg_hit = SEL_IMG_DATA;
			default: reg_hit = SEL_NONE;
		endcase
	endfunction : reg_hit

	// ************************************************
	// axi4-lite write path
	// ************************************************
	// address and data are held until both have arrived
	assign wr_fire = !awready_reg && !wready_reg && !bvalid_reg;
	assign wsel = reg_hit(awaddr_reg);

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			awready_reg <= 1'b1;
			awaddr_reg <= 8'h00;
		end else if (awready_reg && s_axi_awvalid) begin
			awready_reg <= 1'b0;
			awaddr_reg <= s_axi_awaddr;
		end else if (bvalid_reg && s_axi_bready) begin
			awready_reg <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			wready_reg <= 1'b1;
			wdata_reg <= 32'h0;
			wstrb_reg <= 4'h0;
		end else if (wready_reg && s_axi_wvalid) begin
			wready_reg <= 1'b0;
			wdata_reg <= s_axi_wdata;
			wstrb_reg <= s_axi_wstrb;
		end else if (bvalid_reg && s_axi_bready) begin
			wready_reg <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// ************************************************
	// axi4-lite read path
	// ************************************************
	assign rsel = reg_hit(s_axi_araddr);

	always_comb begin
		rd_word = 32'h0;
		case (rsel)
			SEL_CTRL: begin
				rd_word[CTRL_MODE_LSB +: MODE_W] = mode_reg;
				rd_word[CTRL_LAST_LSB +: IDX_W] = last_reg;
			end
			SEL_STATUS: begin
				rd_word[ST_BUSY_BIT] = busy_reg;
				rd_word[ST_DONE_BIT] = load_done_reg;
				rd_word[ST_LOADING_BIT] = (ld_state_reg != LD_IDLE);
				rd_word[ST_MODE_ERR_BIT] = mode_err_reg;
				rd_word[ST_OC_DONE_BIT] = oc_done_reg;
				rd_word[ST_IDX_LSB +: IDX_W] = word_idx_reg;
			end
			SEL_IMG_ADDR: rd_word[IDX_W-1:0] = img_addr_reg;
			SEL_IMG_DATA: rd_word[WORD_W-1:0] = img_mem[img_addr_reg];
			default: rd_word = 32'h0;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0;
			rresp_reg <= RESP_OKAY;
		end else if (arready_reg && s_axi_arvalid) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_word;
			rresp_reg <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
			arready_reg <= 1'b1;
		end
	end

	// ************************************************
	// control registers and image memory
	// ************************************************
	always_ff @(posedge sys_clk) begin
		// R4: clear on reset
		if (!nrst) begin
			mode_reg <= RST_MODE;
			last_reg <= RST_LAST;
			start_req_reg <= 1'b0;
			clr_req_reg <= 1'b0;
		end else begin
			// R3: one-cycle pulse
			start_req_reg <= 1'b0;
			clr_req_reg <= 1'b0;
			if (wr_fire && wsel == SEL_CTRL) begin
				if (wstrb_reg[0])
					mode_reg <= wdata_reg[CTRL_MODE_LSB +: MODE_W];
				if (wstrb_reg[1])
					last_reg <= wdata_reg[CTRL_LAST_LSB +: IDX_W];
				if (wstrb_reg[2]) begin
					start_req_reg <= wdata_reg[CTRL_START_BIT];
					clr_req_reg <= wdata_reg[CTRL_CLEAR_BIT];
				end
			end
		end
	end

	// the image pointer steps on each full data write, so a burst of writes fills it in order
	always_ff @(posedge sys_clk) begin
		if (!nrst)
			img_addr_reg <= '0;
		else if (wr_fire && wsel == SEL_IMG_ADDR && wstrb_reg[0])
			img_addr_reg <= wdata_reg[IDX_W-1:0];
		else if (wr_fire && wsel == SEL_IMG_DATA && (&wstrb_reg[1:0]))
			img_addr_reg <= idx_t'(img_addr_reg + 1'b1);
	end

	// image contents are data, not control state, so reset leaves them alone
	always_ff @(posedge sys_clk) begin
		if (wr_fire && wsel == SEL_IMG_DATA && (&wstrb_reg[1:0]))
			img_mem[img_addr_reg] <= wdata_reg[WORD_W-1:0];
	end

	// ************************************************
	// channel image loader
	// ************************************************
	// R21: only the channel code loads; R20: no pll code exists
	assign start_ok = start_req_reg && mode_reg == MODE_CHANNEL && ld_state_reg == LD_IDLE
		&& oc_state_reg == OC_DONE;

	always_ff @(posedge sys_clk) begin
		if (!nrst)
			mode_err_reg <= 1'b0;
		else if (start_req_reg && mode_reg != MODE_CHANNEL)
			mode_err_reg <= 1'b1;
		else if (start_ok)
			mode_err_reg <= 1'b0;
	end

	always_ff @(posedge sys_clk) begin
		// R4: abort load
		if (!nrst) begin
			ld_state_reg <= LD_IDLE;
			word_idx_reg <= '0;
			strobe_reg <= 1'b0;
			load_done_reg <= 1'b0;
			wr_en_reg <= 1'b0;
			wr_addr_reg <= '0;
			wr_data_reg <= '0;
		end else begin
			strobe_reg <= 1'b0;
			case (ld_state_reg)
				LD_IDLE: begin
					// R7: done cleared on start
					if (start_ok) begin
						load_done_reg <= 1'b0;
						ld_state_reg <= LD_FETCH;
					end
				end
				LD_FETCH: begin
					// R18: word out on bus
					wr_en_reg <= 1'b1;
					wr_addr_reg <= word_idx_reg;
					wr_data_reg <= img_mem[word_idx_reg];
					ld_state_reg <= LD_WRITE;
				end
				LD_WRITE: begin
					if (from_xcvr.wr_ack) begin
						// R2: strobe after word
						wr_en_reg <= 1'b0;
						strobe_reg <= 1'b1;
						// R1: step or wrap
						if (word_idx_reg == last_reg) begin
							word_idx_reg <= '0;
							// R6: last word written
							load_done_reg <= 1'b1;
							ld_state_reg <= LD_IDLE;
						end else begin
							word_idx_reg <= idx_t'(word_idx_reg + 1'b1);
							ld_state_reg <= LD_FETCH;
						end
					end
				end
				default: ld_state_reg <= LD_IDLE;
			endcase
			// R3: clear wins over step
			if (clr_req_reg)
				word_idx_reg <= '0;
		end
	end

	// ************************************************
	// offset cancellation sequencer
	// ************************************************
	// the once-only flag survives the controller reset; only power-on reset clears it
	always_ff @(posedge sys_clk) begin
		if (!por_n) begin
			oc_done_reg <= 1'b0;
			oc_state_reg <= OC_WAIT;
			oc_cnt_reg <= 4'h0;
			busy_reg <= 1'b0;
			isolate_reg <= 1'b0;
			settle_reg <= 1'b0;
			buffer_reg <= 1'b0;
		end else if (!nrst) begin
			// R9: R10: R11: hold, restart or stay done
			oc_state_reg <= oc_done_reg ? OC_DONE : OC_WAIT;
			oc_cnt_reg <= 4'h0;
			busy_reg <= 1'b0;
			isolate_reg <= 1'b0;
			settle_reg <= 1'b0;
			buffer_reg <= 1'b0;
		end else begin
			case (oc_state_reg)
				OC_WAIT: begin
					// R8: R19: start only with a receiver
					if (HAS_RX) begin
						// R12: R15: isolate pins, raise busy
						oc_state_reg <= OC_ISOLATE;
						busy_reg <= 1'b1;
						isolate_reg <= 1'b1;
					end else begin
						oc_state_reg <= OC_DONE;
						oc_done_reg <= 1'b1;
					end
				end
				OC_ISOLATE: begin
					oc_state_reg <= OC_SETTLE;
					settle_reg <= 1'b1;
					oc_cnt_reg <= 4'h0;
				end
				OC_SETTLE: begin
					// R17: fixed length
					if (oc_cnt_reg == OC_SETTLE_LAST) begin
						oc_state_reg <= OC_BUFFER;
						settle_reg <= 1'b0;
						buffer_reg <= 1'b1;
					end else begin
						oc_cnt_reg <= 4'(oc_cnt_reg + 1'b1);
					end
				end
				OC_BUFFER: begin
					// R13: R16: buffer step, then release
					oc_state_reg <= OC_DONE;
					buffer_reg <= 1'b0;
					isolate_reg <= 1'b0;
					busy_reg <= 1'b0;
					oc_done_reg <= 1'b1;
				end
				OC_DONE: oc_state_reg <= OC_DONE;
				default: oc_state_reg <= OC_WAIT;
			endcase
		end
	end

	// ************************************************
	// outputs
	// ************************************************
	// R22: every output from a flop
	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign to_xcvr = '{rx_isolate: isolate_reg, oc_settle: settle_reg, oc_buffer: buffer_reg,
		wr_en: wr_en_reg, wr_addr: wr_addr_reg, wr_data: wr_data_reg};
	assign busy = busy_reg;
	assign word_idx = word_idx_reg;
	assign word_idx_strobe = strobe_reg;
	assign load_done = load_done_reg;

	// ************************************************
	// assertions
	// ************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst || !por_n);

	property p_idx_step;
		strobe_reg |-> (word_idx_reg == idx_t'($past(word_idx_reg) + 1'b1)) || (word_idx_reg == '0);
	endproperty
	a_idx_step: assert property (p_idx_step) else $error("word index did not step or wrap"); // R1

	property p_strobe_after_word;
		strobe_reg |-> $past(wr_en_reg && from_xcvr.wr_ack);
	endproperty
	a_strobe_after_word: assert property (p_strobe_after_word) else $error("strobe without word"); // R2

	property p_clear_zero;
		clr_req_reg |=> word_idx_reg == '0;
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("clear did not zero index"); // R3

	property p_done_on_wrap;
		(ld_state_reg == LD_WRITE && from_xcvr.wr_ack && word_idx_reg == last_reg && !clr_req_reg)
			|=> load_done_reg && word_idx_reg == '0 && ld_state_reg == LD_IDLE;
	endproperty
	a_done_on_wrap: assert property (p_done_on_wrap) else $error("no done after last word"); // R6

	property p_done_cleared;
		start_ok |=> !load_done_reg && ld_state_reg == LD_FETCH ##1 wr_en_reg;
	endproperty
	a_done_cleared: assert property (p_done_cleared) else $error("done not cleared at start"); // R7

	property p_oc_once;
		oc_done_reg |=> oc_done_reg && !busy_reg;
	endproperty
	a_oc_once: assert property (p_oc_once) else $error("cancellation ran again"); // R9

	property p_busy_first;
		(HAS_RX && oc_state_reg == OC_WAIT) |-> !busy_reg ##1 busy_reg && isolate_reg;
	endproperty
	a_busy_first: assert property (p_busy_first) else $error("busy not raised in second cycle"); // R15

	property p_busy_len;
		$rose(busy_reg) |-> busy_reg[*8] ##1 busy_reg[*8] ##1 !busy_reg;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("cancellation not sixteen cycles"); // R17

	property p_done_at_fall;
		$fell(busy_reg) |-> oc_done_reg && $past(buffer_reg);
	endproperty
	a_done_at_fall: assert property (p_done_at_fall) else $error("busy fell before buffer step"); // R16

	property p_isolate;
		busy_reg |-> isolate_reg;
	endproperty
	a_isolate: assert property (p_isolate) else $error("pins not isolated while busy"); // R12

	property p_mode_gate;
		(start_req_reg && mode_reg != MODE_CHANNEL && ld_state_reg == LD_IDLE)
			|=> ld_state_reg == LD_IDLE && mode_err_reg;
	endproperty
	a_mode_gate: assert property (p_mode_gate) else $error("load started in wrong mode"); // R21

	property p_no_rx;
		!HAS_RX |-> !busy_reg && !isolate_reg;
	endproperty
	a_no_rx: assert property (p_no_rx) else $error("cancellation without receiver"); // R19

	c_full_load: cover property (load_done_reg && strobe_reg);
	c_oc_done: cover property ($fell(busy_reg));
	c_clear_in_load: cover property (clr_req_reg && ld_state_reg == LD_WRITE);
	c_mode_err: cover property ($rose(mode_err_reg));

endmodule : xcvr_reconfig_offset_cancel

// ==== bench/xcvr_channel_model.sv ====
// behavioural transceiver channel answering image word writes
`timescale 1ns/1ps

module xcvr_channel_model (
	// clock
	input wire logic sys_clk,
	// transceiver buses
	input wire xcvr_reconfig_pkg::to_xcvr_t to_xcvr,
	output xcvr_reconfig_pkg::from_xcvr_t from_xcvr,
	// answer pacing in cycles
	input wire logic [7:0] ack_delay
);
	import xcvr_reconfig_pkg::*;

	logic [7:0] wait_reg = 8'h00;
	word_t seen_data [MEM_DEPTH];
	// no power-down input exists here, so the channel stays powered through cancellation

	initial begin
		from_xcvr = '0;
	end

	// ************************************************
	// word write answer
	// ************************************************
	// acknowledge each outbound word after a pause
	always @(posedge sys_clk) begin
		if (to_xcvr.wr_en && !from_xcvr.wr_ack && wait_reg >= ack_delay) begin
			from_xcvr.wr_ack <= 1'b1;
			wait_reg <= 8'h00;
		end else if (to_xcvr.wr_en && !from_xcvr.wr_ack) begin
			wait_reg <= wait_reg + 8'h01;
		end else begin
			// ack is dropped at the edge that takes it, so it never lingers
			from_xcvr.wr_ack <= 1'b0;
			wait_reg <= 8'h00;
		end
		if (to_xcvr.wr_en && from_xcvr.wr_ack) begin
			seen_data[to_xcvr.wr_addr] <= to_xcvr.wr_data;
		end
	end
endmodule : xcvr_channel_model

// ==== bench/xcvr_reconfig_offset_cancel_tb.sv ====
// self-checking bench of the image loader and offset cancellation sequencer
`timescale 1ns/1ps

module xcvr_reconfig_offset_cancel_tb;
	import xcvr_reconfig_pkg::*;

	// ************************************************
	// signals
	// ************************************************
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic por_n = 1'b0;
	logic [7:0] aw_addr = 8'h00;
	logic [7:0] ar_addr = 8'h00;
	logic [31:0] w_data = 32'h0;
	logic [3:0] w_strb = 4'h0;
	logic aw_valid = 1'b0;
	logic w_valid = 1'b0;
	logic ar_valid = 1'b0;
	logic aw_ready, w_ready, b_valid, ar_ready, r_valid;
	logic [1:0] b_resp, r_resp;
	logic [31:0] r_data;
	to_xcvr_t tx;
	from_xcvr_t rx;
	logic busy, idx_strobe, load_done;
	idx_t word_idx;
	logic [7:0] ack_delay = 8'h00;
	logic slow = 1'b0;
	int n_errors = 0;
	int check_count = 0;
	int cyc = 0;
	integer seed = 32'h75dc;
	word_t img [MEM_DEPTH];
	idx_t mon_idx = '0;
	idx_t mon_last = '0;

	always #2.5 sys_clk = ~sys_clk;

	xcvr_reconfig_offset_cancel #(.HAS_RX(1'b1)) dut_u (
		.sys_clk(sys_clk), .nrst(nrst), .por_n(por_n),
		.s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_valid), .s_axi_awready(aw_ready),
		.s_axi_wdata(w_data), .s_axi_wstrb(w_strb), .s_axi_wvalid(w_valid), .s_axi_wready(w_ready),
		.s_axi_bresp(b_resp), .s_axi_bvalid(b_valid), .s_axi_bready(1'b1),
		.s_axi_araddr(ar_addr), .s_axi_arvalid(ar_valid), .s_axi_arready(ar_ready),
		.s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid), .s_axi_rready(1'b1),
		.to_xcvr(tx), .from_xcvr(rx),
		.busy(busy), .word_idx(word_idx), .word_idx_strobe(idx_strobe), .load_done(load_done)
	);

	xcvr_channel_model xcvr_u (.sys_clk(sys_clk), .to_xcvr(tx), .from_xcvr(rx), .ack_delay(ack_delay));

	// ************************************************
	// tasks
	// ************************************************
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic conclude;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		logic aw_d;
		logic w_d;
		aw_d = 1'b0;
		w_d = 1'b0;
		aw_addr <= a;
		w_data <= d;
		w_strb <= s;
		aw_valid <= 1'b1;
		w_valid <= 1'b1;
		while (!(aw_d && w_d)) begin
			@(posedge sys_clk);
			if (!aw_d && aw_ready === 1'b1) begin
				aw_d = 1'b1;
				aw_valid <= 1'b0;
			end
			if (!w_d && w_ready === 1'b1) begin
				w_d = 1'b1;
				w_valid <= 1'b0;
			end
		end
		do @(posedge sys_clk); while (b_valid !== 1'b1);
		r = b_resp;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		ar_addr <= a;
		ar_valid <= 1'b1;
		do @(posedge sys_clk); while (ar_ready !== 1'b1);
		ar_valid <= 1'b0;
		do @(posedge sys_clk); while (r_valid !== 1'b1);
		d = r_data;
		r = r_resp;
	endtask : axi_rd

	function automatic logic [31:0] ctrl(input logic [1:0] sc, input idx_t last, input logic [2:0] mode);
		return {14'h0000, sc, 2'b00, last, 5'h00, mode};
	endfunction : ctrl

	task automatic oc_run;
		int n;
		int first;
		int nbuf;
		int nset;
		logic pb;
		logic pbuf;
		n = 0;
		first = 0;
		nbuf = 0;
		pb = 1'b0;
		pbuf = 1'b0;
		nset = 0;
		// the first cycle after release is the one already running, so busy must still be low
		chk("busy_first", busy, 1'b0);
		for (int k = 1; k <= 24; k++) begin
			@(posedge sys_clk);
			#1;
			if (busy === 1'b1 && first == 0) first = k;
			n += int'(busy === 1'b1);
			nbuf += int'(tx.oc_buffer === 1'b1);
			nset += int'(tx.oc_settle === 1'b1);
			chk("isolate", tx.rx_isolate, busy);
			if (pb && busy !== 1'b1) chk("buffer_last", pbuf, 1'b1);
			pb = (busy === 1'b1);
			pbuf = tx.oc_buffer;
		end
		chk("busy_second", first, 1);
		chk("busy_len", n, OC_CYCLES);
		chk("buffer_once", nbuf, 1);
		chk("settle_len", nset, OC_CYCLES - 2);
		chk("busy_end", busy, 1'b0);
	endtask : oc_run

	task automatic load(input idx_t last);
		logic [1:0] r;
		axi_wr(OFS_IMG_ADDR, 32'h0, 4'h1, r);
		for (int i = 0; i <= int'(last); i++) begin
			img[i] = word_t'($random(seed));
			axi_wr(OFS_IMG_DATA, {16'h0000, img[i]}, 4'h3, r);
		end
		mon_idx = '0;
		mon_last = last;
		axi_wr(OFS_CTRL, ctrl(2'b01, last, MODE_CHANNEL), 4'h7, r);
		chk("wr_okay", r, RESP_OKAY);
	endtask : load

	task automatic wait_done(input idx_t last);
		int k;
		k = 0;
		while (load_done !== 1'b1 && k < 2000) begin
			@(posedge sys_clk);
			#1;
			k++;
		end
		chk("load_done", load_done, 1'b1);
		chk("idx_wrap", word_idx, 6'h00);
		for (int i = 0; i <= int'(last); i++) begin
			chk("image_word", xcvr_u.seen_data[i], img[i]);
		end
	endtask : wait_done

	// strobe must follow each taken word; index steps and wraps
	always @(posedge sys_clk) begin : idx_monitor
		logic taken;
		logic live;
		taken = tx.wr_en && rx.wr_ack;
		live = nrst;
		#1;
		if (live) begin
			chk("idx_strobe", idx_strobe, taken);
			if (taken) begin
				mon_idx = (mon_idx == mon_last) ? '0 : mon_idx + 1'b1;
				chk("word_idx", word_idx, mon_idx);
				if (!slow) ack_delay <= 8'($random(seed) & 3);
			end
		end
	end

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			conclude();
		end
	end

	initial begin
		logic [1:0] r;
		logic [31:0] d;
		int n;
		int k;
		idx_t last;
		// reset changes only at sys_clk edges, so it arrives synchronised
		tick(12);
		por_n <= 1'b1;
		repeat (6) begin
			@(posedge sys_clk);
			#1;
			chk("busy_held", busy, 1'b0);
		end
		nrst <= 1'b1;
		oc_run();
		// power up again and interrupt the sequence halfway
		por_n <= 1'b0;
		tick(2);
		por_n <= 1'b1;
		tick(8);
		#1;
		chk("busy_mid", busy, 1'b1);
		nrst <= 1'b0;
		tick(2);
		#1;
		chk("busy_abandon", busy, 1'b0);
		nrst <= 1'b1;
		oc_run();
		nrst <= 1'b0;
		tick(2);
		nrst <= 1'b1;
		n = 0;
		repeat (30) begin
			@(posedge sys_clk);
			#1;
			n += int'(busy === 1'b1);
		end
		chk("busy_rerun", n, 0);
		axi_rd(OFS_STATUS, d, r);
		chk("oc_done", d[ST_OC_DONE_BIT], 1'b1);
		axi_rd(8'h10, d, r);
		chk("rd_unmapped", d, 32'h0);
		chk("rd_unmapped_resp", r, RESP_SLVERR);
		axi_wr(8'h14, 32'hffff_ffff, 4'hf, r);
		chk("wr_unmapped", r, RESP_SLVERR);
		for (int m = 0; m < 8; m++) begin
			if (m != 1) begin
				axi_wr(OFS_CTRL, ctrl(2'b01, RST_LAST, 3'(m)), 4'h7, r);
				tick(3);
				axi_rd(OFS_STATUS, d, r);
				chk("mode_err", d[ST_MODE_ERR_BIT], 1'b1);
				chk("no_load", d[ST_LOADING_BIT], 1'b0);
			end
		end
		last = idx_t'(($random(seed) & 3) + 1);
		load(last);
		axi_rd(OFS_STATUS, d, r);
		chk("mode_ok", d[ST_MODE_ERR_BIT], 1'b0);
		wait_done(last);
		// image pointer sits past the last word written; read the first word back
		axi_rd(OFS_IMG_ADDR, d, r);
		chk("img_addr", d, 32'(last) + 32'h1);
		axi_wr(OFS_IMG_ADDR, 32'h0, 4'h1, r);
		axi_rd(OFS_IMG_DATA, d, r);
		chk("img_data", d, {16'h0000, img[0]});
		load(6'h02);
		@(posedge sys_clk);
		#1;
		chk("done_cleared", load_done, 1'b0);
		wait_done(6'h02);
		// slow channel: clear the index mid-load, then abort by reset
		slow = 1'b1;
		ack_delay <= 8'h1e;
		load(6'h05);
		k = 0;
		while (word_idx !== 6'h02 && k < 500) begin
			@(posedge sys_clk);
			k++;
		end
		axi_wr(OFS_CTRL, ctrl(2'b10, 6'h05, MODE_CHANNEL), 4'h7, r);
		tick(2);
		#1;
		chk("idx_clear", word_idx, 6'h00);
		mon_idx = '0;
		// let one more word land so that the reset has a live index and a pending write to clear
		k = 0;
		while (word_idx !== 6'h01 && k < 500) begin
			@(posedge sys_clk);
			k++;
		end
		nrst <= 1'b0;
		tick(2);
		#1;
		chk("abort_wr", tx.wr_en, 1'b0);
		chk("abort_idx", word_idx, 6'h00);
		chk("abort_done", load_done, 1'b0);
		nrst <= 1'b1;
		slow = 1'b0;
		axi_rd(OFS_STATUS, d, r);
		chk("abort_loading", d[ST_LOADING_BIT], 1'b0);
		axi_rd(OFS_CTRL, d, r);
		chk("ctrl_reset", d, ctrl(2'b00, RST_LAST, RST_MODE));
		conclude();
	end
endmodule : xcvr_reconfig_offset_cancel_tb
